// File: include/sstfr_pkg.sv
// constants of the spi slave transmit, format and fill-character registers
// assumes a 12-bit APB byte address and 32-bit data words
package sstfr_pkg;
  // ==========================================================
  // register byte offsets
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_RX_COUNT = 12'h53C;
  localparam logic [11:0] OFS_RX_LIST = 12'h540;
  localparam logic [11:0] OFS_TX_PTR = 12'h544;
  localparam logic [11:0] OFS_TX_LIMIT = 12'h548;
  localparam logic [11:0] OFS_TX_SENT = 12'h54C;
  localparam logic [11:0] OFS_TX_LIST = 12'h550;
  localparam logic [11:0] OFS_CONFIG = 12'h554;
  localparam logic [11:0] OFS_DEF_CHAR = 12'h55C;
  localparam logic [11:0] OFS_ORC_CHAR = 12'h5C0;

  // ==========================================================
  // field positions and widths
  localparam int LIST_BIT = 0;
  localparam int CFG_ORDER_BIT = 0;
  localparam int CFG_PHASE_BIT = 1;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_W = 3;
  localparam int COUNT_W = 10;
  localparam int CHAR_W = 8;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // field encodings
  localparam logic LIST_DISABLED = 1'b0;
  localparam logic LIST_ARRAY = 1'b1;
  localparam logic ORDER_HIGH_FIRST = 1'b0;
  localparam logic ORDER_LOW_FIRST = 1'b1;
  localparam logic [9:0] COUNT_MAX = 10'h3FF;

  // ==========================================================
  // reset values
  localparam logic RST_LIST = 1'b0;
  localparam logic [31:0] RST_PTR = 32'h00000000;
  localparam logic [9:0] RST_LIMIT = 10'h000;
  localparam logic [9:0] RST_COUNT = 10'h000;
  localparam logic [2:0] RST_CFG = 3'h0;
  localparam logic [7:0] RST_CHAR = 8'h00;

  // ==========================================================
  // transaction states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SERVE = 3'b010,
    ST_IGNORE = 3'b100
  } sstfr_state_t;
endpackage

// File: verilog/sstfr_spi_slave.sv
// spi slave: APB registers, byte fetch from a transmit buffer, serial shifter
// assumes an external master owning sck and csnN, a tx memory that answers a
// read one cycle after txMemRead, and neighbouring logic granting the buffers
//
// Function
// - both list-mode fields: 0 disables list, 1 selects array list; reset 0
// - transmit limit holds 0..0x3FF, bytes fetchable per granted transaction
// - read-only count of buffer bytes sent in last granted transaction, held at the transmit limit
// - legacy pointer, limit and count names share the newer registers' storage
// - order bit: 0 high bit first, 1 low bit first, both directions
// - phase 0 samples leading edge; phase 1 samples trailing edge
// - polarity 0 clock active high, 1 active low, matching master idle
// - ignored transaction shifts out the default fill character
// - bytes beyond the transmit limit shift out the over-read character
// - read-only count of bytes received in last granted transaction
`timescale 1ns/10ps
module sstfr_spi_slave #(
  parameter int COUNT_W = sstfr_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sstfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck,
  input wire logic csnN,
  input wire logic mosi,
  output logic misoOut,
  output logic misoOe,
  input wire logic bufGranted,
  output logic txMemRead,
  output logic [31:0] txMemAddr,
  input wire logic [sstfr_pkg::CHAR_W-1:0] txMemData,
  output logic [sstfr_pkg::CHAR_W-1:0] rxByte,
  output logic rxByteStrobe,
  output logic txListMode,
  output logic rxListMode
);
  import sstfr_pkg::*;

  // ==========================================================
  // elaboration check
  // reset and saturation constants are 10 bits wide
  if (COUNT_W < 1 || COUNT_W > 10) begin : g_bad_width
    $error("COUNT_W must lie between 1 and 10");
  end

  // ==========================================================
  // functions
  function automatic logic pickBit(input logic [7:0] b,
                                   input logic [2:0] idx,
                                   input logic lowFirst);
    return lowFirst ? b[idx] : b[3'd7 - idx];
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] b,
                                         input logic d,
                                         input logic lowFirst);
    return lowFirst ? {d, b[7:1]} : {b[6:0], d};
  endfunction

  function automatic logic [31:0] widen(input logic [COUNT_W-1:0] v);
    return {{(32-COUNT_W){1'b0}}, v};
  endfunction

  // ==========================================================
  // register storage
  logic rxList_q;
  logic txList_q;
  logic [31:0] txPtr_q;
  logic [COUNT_W-1:0] txLimit_q;
  logic [CFG_W-1:0] cfg_q;
  logic [CHAR_W-1:0] defChar_q;
  logic [CHAR_W-1:0] orcChar_q;
  logic [COUNT_W-1:0] txIdx_q;
  logic [COUNT_W-1:0] rxCnt_q;
  logic lowFirst;
  logic [31:0] rdData;
  logic rdHit;
  logic rdOnly;
  logic wrEn;

  assign lowFirst = cfg_q[CFG_ORDER_BIT];
  assign wrEn = psel & penable & pwrite;
  assign txListMode = txList_q;
  assign rxListMode = rxList_q;

  // ==========================================================
  // apb slave
  // zero wait states: setup latches the answer, access completes
  assign pready = psel & penable;

  always_comb begin
    rdData = 32'h00000000;
    rdHit = 1'b1;
    rdOnly = 1'b0;
    // one decode per offset, so both names share storage
    if (paddr == OFS_RX_COUNT) begin
      rdData = widen(rxCnt_q);
      rdOnly = 1'b1;
    end else if (paddr == OFS_RX_LIST) begin
      rdData[LIST_BIT] = rxList_q;
    end else if (paddr == OFS_TX_PTR) begin
      rdData = txPtr_q;
    end else if (paddr == OFS_TX_LIMIT) begin
      rdData = widen(txLimit_q);
    end else if (paddr == OFS_TX_SENT) begin
      rdData = widen(txIdx_q);
      rdOnly = 1'b1;
    end else if (paddr == OFS_TX_LIST) begin
      rdData[LIST_BIT] = txList_q;
    end else if (paddr == OFS_CONFIG) begin
      rdData[CFG_W-1:0] = cfg_q;
    end else if (paddr == OFS_DEF_CHAR) begin
      rdData[CHAR_W-1:0] = defChar_q;
    end else if (paddr == OFS_ORC_CHAR) begin
      rdData[CHAR_W-1:0] = orcChar_q;
    end else begin
      rdHit = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h00000000 : rdData;
      pslverr <= ~rdHit | (pwrite & rdOnly);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxList_q <= RST_LIST;
      txList_q <= RST_LIST;
    end else if (wrEn && paddr == OFS_RX_LIST) begin
      rxList_q <= pwdata[LIST_BIT];
    end else if (wrEn && paddr == OFS_TX_LIST) begin
      txList_q <= pwdata[LIST_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txPtr_q <= RST_PTR;
      txLimit_q <= RST_LIMIT[COUNT_W-1:0];
    end else if (wrEn && paddr == OFS_TX_PTR) begin
      txPtr_q <= pwdata;
    end else if (wrEn && paddr == OFS_TX_LIMIT) begin
      txLimit_q <= pwdata[COUNT_W-1:0];
    end
  end

  // format and fill characters; change them only while csnN is high
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_q <= RST_CFG;
      defChar_q <= RST_CHAR;
      orcChar_q <= RST_CHAR;
    end else if (wrEn && paddr == OFS_CONFIG) begin
      cfg_q <= pwdata[CFG_W-1:0];
    end else if (wrEn && paddr == OFS_DEF_CHAR) begin
      defChar_q <= pwdata[CHAR_W-1:0];
    end else if (wrEn && paddr == OFS_ORC_CHAR) begin
      orcChar_q <= pwdata[CHAR_W-1:0];
    end
  end

  // ==========================================================
  // link domain
  logic kClk;
  logic [2:0] bitCnt_q;
  logic [7:0] rxShift_q;
  logic [7:0] curByte_q;
  logic [7:0] rxHold_q;
  logic rxTog_q;
  logic txTog_q;
  logic outBit_q;
  logic noFall_q;
  logic [7:0] offer_q;

  // one internal clock: sampling on its rise, shifting on its fall
  assign kClk = sck ^ cfg_q[CFG_POL_BIT] ^ cfg_q[CFG_PHASE_BIT];
  assign misoOe = ~csnN;

  // first bit stands before any shifting edge
  assign misoOut = noFall_q ? pickBit(offer_q, 3'd0, lowFirst) : outBit_q;

  always_ff @(posedge kClk or posedge csnN) begin
    if (csnN) begin
      bitCnt_q <= 3'd0;
      rxShift_q <= 8'h00;
      curByte_q <= 8'h00;
    end else begin
      bitCnt_q <= bitCnt_q + 3'd1;
      rxShift_q <= shiftIn(rxShift_q, mosi, lowFirst);
      if (bitCnt_q == 3'd0) begin
        curByte_q <= offer_q;
      end
    end
  end

  // toggles survive csnN so no event is lost or invented at frame end
  always_ff @(posedge kClk or posedge rst) begin
    if (rst) begin
      rxTog_q <= 1'b0;
      txTog_q <= 1'b0;
      rxHold_q <= 8'h00;
    end else if (!csnN) begin
      if (bitCnt_q == 3'd7) begin
        rxHold_q <= shiftIn(rxShift_q, mosi, lowFirst);
        rxTog_q <= ~rxTog_q;
      end
      if (bitCnt_q == 3'd0) begin
        txTog_q <= ~txTog_q;
      end
    end
  end

  always_ff @(negedge kClk or posedge csnN) begin
    if (csnN) begin
      outBit_q <= 1'b0;
      noFall_q <= 1'b1;
    end else begin
      noFall_q <= 1'b0;
      if (bitCnt_q == 3'd0) begin
        outBit_q <= pickBit(offer_q, 3'd0, lowFirst);
      end else begin
        outBit_q <= pickBit(curByte_q, bitCnt_q, lowFirst);
      end
    end
  end

  // ==========================================================
  // crossings into clk
  logic [SYNC_STAGES-1:0] csnS_q;
  logic [SYNC_STAGES-1:0] txS_q;
  logic [SYNC_STAGES-1:0] rxS_q;
  logic txSeen_q;
  logic rxSeen_q;
  logic csnLow;
  logic csnHigh;
  logic txEv;
  logic rxEv;

  always_ff @(posedge clk) begin
    if (rst) begin
      csnS_q <= '1;
      txS_q <= '0;
      rxS_q <= '0;
    end else begin
      csnS_q <= {csnS_q[SYNC_STAGES-2:0], csnN};
      txS_q <= {txS_q[SYNC_STAGES-2:0], txTog_q};
      rxS_q <= {rxS_q[SYNC_STAGES-2:0], rxTog_q};
    end
  end

  assign csnLow = ~csnS_q[1] & ~csnS_q[2];
  assign csnHigh = csnS_q[1] & csnS_q[2];
  assign txEv = (txS_q[1] == txS_q[2]) && (txS_q[2] != txSeen_q);
  assign rxEv = (rxS_q[1] == rxS_q[2]) && (rxS_q[2] != rxSeen_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      txSeen_q <= 1'b0;
      rxSeen_q <= 1'b0;
    end else begin
      if (txS_q[1] == txS_q[2]) begin
        txSeen_q <= txS_q[2];
      end
      if (rxS_q[1] == rxS_q[2]) begin
        rxSeen_q <= rxS_q[2];
      end
    end
  end

  // ==========================================================
  // transaction control
  sstfr_state_t state_q;
  logic enterServe;

  assign enterServe = (state_q == ST_IDLE) && csnLow && bufGranted;

  // grant is judged once, as the frame opens
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (csnLow) begin
            state_q <= bufGranted ? ST_SERVE : ST_IGNORE;
          end
        end
        ST_SERVE, ST_IGNORE: begin
          if (csnHigh) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sent count doubles as fetch index, held at the limit
  always_ff @(posedge clk) begin
    if (rst) begin
      txIdx_q <= RST_COUNT[COUNT_W-1:0];
    end else if (enterServe) begin
      txIdx_q <= '0;
    end else if (state_q == ST_SERVE && txEv && txIdx_q < txLimit_q) begin
      txIdx_q <= txIdx_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rxCnt_q <= RST_COUNT[COUNT_W-1:0];
      rxByte <= 8'h00;
      rxByteStrobe <= 1'b0;
    end else begin
      rxByteStrobe <= 1'b0;
      if (enterServe) begin
        rxCnt_q <= '0;
      end else if (state_q == ST_SERVE && rxEv) begin
        rxByte <= rxHold_q;
        rxByteStrobe <= 1'b1;
        if (rxCnt_q != COUNT_MAX[COUNT_W-1:0]) begin
          rxCnt_q <= rxCnt_q + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // byte supply
  // in a frame the pipe fetches one byte ahead so that a 7-bit window
  // covers crossing latency; when idle it prepares the first byte
  logic [COUNT_W:0] reqIdx;
  logic grantView;
  logic fetchNow;
  logic toAhead_q;
  logic toAheadD_q;
  logic rdPend_q;
  logic [7:0] fill_q;
  logic [7:0] fillD_q;
  logic [7:0] ahead_q;
  logic [7:0] pipeOut;

  assign reqIdx = (state_q == ST_SERVE) ? {1'b0, txIdx_q} + 1'b1 : '0;
  assign grantView = (state_q == ST_SERVE) ||
                     (state_q == ST_IDLE && bufGranted);
  // no fetch at or past the limit
  assign fetchNow = grantView && (reqIdx < {1'b0, txLimit_q});
  assign pipeOut = rdPend_q ? txMemData : fillD_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      txMemRead <= 1'b0;
      txMemAddr <= 32'h00000000;
      fill_q <= RST_CHAR;
      toAhead_q <= 1'b0;
      rdPend_q <= 1'b0;
      fillD_q <= RST_CHAR;
      toAheadD_q <= 1'b0;
    end else begin
      txMemRead <= fetchNow;
      txMemAddr <= txPtr_q + 32'(reqIdx);
      // ignored frame sends default, past limit over-read
      fill_q <= grantView ? orcChar_q : defChar_q;
      toAhead_q <= (state_q == ST_SERVE);
      rdPend_q <= txMemRead;
      fillD_q <= fill_q;
      toAheadD_q <= toAhead_q;
    end
  end

  // offer_q is read by the link only while it is stable
  always_ff @(posedge clk) begin
    if (rst) begin
      offer_q <= RST_CHAR;
      ahead_q <= RST_CHAR;
    end else if (state_q == ST_SERVE && txEv) begin
      offer_q <= ahead_q;
    end else if (toAheadD_q) begin
      ahead_q <= pipeOut;
    end else begin
      offer_q <= pipeOut;
    end
  end
endmodule

// File: verif/sstfr_spi_slave_chk.sv
// checker: APB and link-side relations at the slave's ports
// assumes a bind onto sstfr_spi_slave, ports connected by name
`timescale 1ns/10ps
module sstfr_spi_slave_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sstfr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic csnN,
  input wire logic misoOe,
  input wire logic rxByteStrobe,
  input wire logic txListMode,
  input wire logic rxListMode
);
  import sstfr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] wdata_q;
  always_ff @(posedge clk) begin
    wdata_q <= pwdata;
  end
  // ======
  // sequences
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence wr_acc_s(logic [11:0] a);
    psel && penable && pwrite && paddr == a;
  endsequence
  function automatic logic mapped(logic [11:0] a);
    return a inside {OFS_RX_COUNT, OFS_RX_LIST, OFS_TX_PTR, OFS_TX_LIMIT,
      OFS_TX_SENT, OFS_TX_LIST, OFS_CONFIG, OFS_DEF_CHAR, OFS_ORC_CHAR};
  endfunction
  // ======
  // assertions
  acc_ready_a: assert property (setup_s ##1 (psel && penable) |-> pready)
    else $error("no ready in access");
  read_stands_a: assert property (setup_s ##1 (psel && penable)
    |=> $stable(prdata)) else $error("read data moved");
  oe_select_a: assert property (misoOe == !csnN)
    else $error("output enable wrong");
  unmapped_err_a: assert property ((psel && !penable && !mapped(paddr))
    |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  mapped_ok_a: assert property ((psel && !penable && !pwrite
    && mapped(paddr)) |=> !pslverr) else $error("mapped read refused");
  ro_write_a: assert property (
    (psel && !penable && pwrite && (paddr == OFS_TX_SENT
    || paddr == OFS_RX_COUNT)) |=> pslverr) else $error("count written");
  strobe_pulse_a: assert property (rxByteStrobe |=> !rxByteStrobe)
    else $error("strobe too long");
  tx_list_a: assert property (
    wr_acc_s(OFS_TX_LIST) |=> txListMode == wdata_q[LIST_BIT])
    else $error("tx list not updated");
  rx_list_a: assert property (
    wr_acc_s(OFS_RX_LIST) |=> rxListMode == wdata_q[LIST_BIT])
    else $error("rx list not updated");
  reset_clear_a: assert property (
    $fell(rst) |-> !txListMode && !rxListMode && !rxByteStrobe)
    else $error("reset left state");
endmodule

// File: verif/sstfr_spi_master_model.sv
// far side: behavioural spi master owning sck, select and mosi
// assumes cfg is set by the bench before each frame; txb keeps its initial bytes
`timescale 1ns/10ps
module sstfr_spi_master_model (
  output logic sck,
  output logic csnN,
  output logic mosi,
  input wire logic miso
);
  logic [2:0] cfg = 3'h0;
  logic [7:0] txb [3] = '{8'h1E, 8'hA1, 8'h96};
  logic [7:0] rxb [3];
  initial begin
    sck = 1'b0;
    csnN = 1'b1;
    mosi = 1'b0;
  end
  // off the 100 ns grid so select never meets a clk edge
  task automatic frame(input int n);
    int ix;
    #10 sck = cfg[2];
    #1000 csnN = 1'b0;
    #1000;
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 8; k++) begin
        ix = cfg[0] ? k : 7 - k;
        if (!cfg[1]) mosi = txb[i][ix];
        #20 sck = ~cfg[2];
        if (cfg[1]) mosi = txb[i][ix];
        else rxb[i][ix] = miso;
        #40 sck = cfg[2];
        if (cfg[1]) rxb[i][ix] = miso;
        #20;
      end
    end
    #200 csnN = 1'b1;
    mosi = ~mosi;
    #1000;
  endtask
endmodule

// File: verif/tb_sstfr_spi_slave.sv
// testbench: register access, frames in all eight link formats
// assumes sstfr_pkg, the slave, the master model and the checker
`timescale 1ns/10ps
module tb_sstfr_spi_slave;
  import sstfr_pkg::*;
  localparam logic [11:0] MAP [9] = '{OFS_RX_COUNT, OFS_RX_LIST,
    OFS_TX_PTR, OFS_TX_LIMIT, OFS_TX_SENT, OFS_TX_LIST, OFS_CONFIG,
    OFS_DEF_CHAR, OFS_ORC_CHAR};
  logic clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic bufGranted = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, txMemAddr;
  logic pready, pslverr, misoOut, misoOe, txMemRead, rxByteStrobe;
  logic txListMode, rxListMode, sck, csnN, mosi, misoW;
  logic [7:0] txMemData = 8'h00, rxByte;
  logic [7:0] rxq [$];
  int nErrors, checksDone;
  // ======
  // design, far-side master, tx memory
  // released miso toggles so a stale bit cannot pass
  assign misoW = misoOe ? misoOut : ~clk;
  sstfr_spi_slave dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sck, .csnN, .mosi, .misoOut,
    .misoOe, .bufGranted, .txMemRead, .txMemAddr, .txMemData, .rxByte,
    .rxByteStrobe, .txListMode, .rxListMode);
  sstfr_spi_master_model m_u (.sck, .csnN, .mosi, .miso(misoW));
  always @(posedge clk) begin
    if (txMemRead) txMemData <= txMemAddr[7:0] ^ 8'hA5;
    // pointer ends in 8'h10 and limit is 2, so 8'h11 is the last fetch
    if (txMemRead && txMemAddr[7:0] > 8'h11) begin
      nErrors++;
      $display("Error at %0t: fetch past the limit", $time);
    end
    if (rxByteStrobe) rxq.push_back(rxByte);
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ======
  // tasks
  task automatic stop_test;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checksDone++;
    if (g !== x) begin
      nErrors++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      nErrors++;
      $display("Error at %0t: no ready from slave", $time);
      stop_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic wrd(input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk({31'h0, e}, 32'h0);
    rd(a, x, 1'b0);
  endtask
  task automatic frame_test(input logic [2:0] c, input logic g);
    logic [7:0] x;
    wrd(OFS_CONFIG, {29'h0, c}, {29'h0, c});
    bufGranted <= g;
    rxq.delete();
    m_u.cfg = c;
    m_u.frame(3);
    if (g) chk(rxq.size(), 32'h3);
    for (int i = 0; i < 3; i++) begin
      x = (8'h10 + 8'(i)) ^ 8'hA5;
      if (i == 2) x = 8'hC3;
      if (!g) x = 8'h3E;
      chk({24'h0, m_u.rxb[i]}, {24'h0, x});
      if (g) chk({24'h0, rxq[i]}, {24'h0, m_u.txb[i]});
    end
    rd(OFS_TX_SENT, 32'h2, 1'b0);
    rd(OFS_RX_COUNT, 32'h3, 1'b0);
    $display("frame test cfg %0d grant %0d done", c, g);
  endtask
  // ======
  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (MAP[i]) rd(MAP[i], 32'h0, 1'b0);
    rd(12'h600, 32'h0, 1'b1);
    apb(1'b1, OFS_TX_SENT, 32'h5, r, e);
    chk({31'h0, e}, 32'h1);
    rd(OFS_TX_SENT, 32'h0, 1'b0);
    $display("reset and access test done");
    for (int v = 1; v >= 0; v--) begin
      wrd(OFS_RX_LIST, v, v);
      wrd(OFS_TX_LIST, v, v);
      chk({30'h0, txListMode, rxListMode}, {30'h0, {2{v[0]}}});
    end
    wrd(OFS_TX_LIMIT, 32'h3FF, 32'h3FF);
    wrd(OFS_TX_LIMIT, 32'hFFFFFC02, 32'h2);
    wrd(OFS_TX_PTR, 32'h87654310, 32'h87654310);
    wrd(OFS_DEF_CHAR, 32'hFFFFFF3E, 32'h3E);
    wrd(OFS_ORC_CHAR, 32'h1C3, 32'hC3);
    $display("register test done");
    for (int c = 0; c < 8; c++) begin
      frame_test(c[2:0], 1'b1);
    end
    frame_test(3'h5, 1'b0);
    // mid-run reset must clear counts and settings left by the frames
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (MAP[i]) rd(MAP[i], 32'h0, 1'b0);
    $display("mid-run reset test done");
    stop_test;
  end
  initial begin
    #1000000;
    nErrors++;
    $display("Error at %0t: run timed out", $time);
    stop_test;
  end
endmodule
bind sstfr_spi_slave sstfr_spi_slave_chk chk_u (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .csnN,
  .misoOe, .rxByteStrobe, .txListMode, .rxListMode);
